// *** hw/nnpe_params.svh ***
`ifndef NNPE_PARAMS_SVH
`define NNPE_PARAMS_SVH

// ==========================================
// encodings
`define NNPE_NEG_OPC        7'h36
`define NNPE_NEG_OPC_MSB    15
`define NNPE_NEG_OPC_LSB    9
`define NNPE_BANK_SEL_BIT   8
`define NNPE_NOP_WORD       16'h0000
`define NNPE_NOP_ALT_HI     4'hF
`define NNPE_POP_WORD       16'h0006

// ==========================================
// data addressing
`define NNPE_ADDR_W         12
`define NNPE_BANK_W         4
`define NNPE_ACCESS_SPLIT   8'h80
`define NNPE_ACCESS_LO_BANK 4'h0
`define NNPE_ACCESS_HI_BANK 4'hF

// ==========================================
// return stack
`define NNPE_PC_W           21
`define NNPE_STACK_DEPTH    31
`define NNPE_STACK_PTR_W    5
`define NNPE_STACK_RESET    21'h000000
`define NNPE_PTR_RESET      5'h00

// ==========================================
// flags
`define NNPE_FLAGS_RESET    5'h00

// ==========================================
// timing
`define NNPE_CLK_PERIOD_NS  100
`define NNPE_INSTR_CYCLE_NS 400
`define NNPE_PHASES         (`NNPE_INSTR_CYCLE_NS / `NNPE_CLK_PERIOD_NS)

`endif

// *** hw/nnpe_pkg.sv ***
`include "nnpe_params.svh"

package nnpe_pkg;

	typedef enum logic [1:0] {
		NNPE_Q1 = 2'b00,
		NNPE_Q2 = 2'b01,
		NNPE_Q3 = 2'b10,
		NNPE_Q4 = 2'b11
	} nnpe_phase_e;

	typedef enum logic [1:0] {
		NNPE_OP_NONE = 2'b00,
		NNPE_OP_NEG  = 2'b01,
		NNPE_OP_NOP  = 2'b10,
		NNPE_OP_POP  = 2'b11
	} nnpe_op_e;

	typedef struct packed {
		logic n;
		logic overflow_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} nnpe_flags_s;

	typedef struct packed {
		logic                     rd_en;
		logic                     wr_en;
		logic [`NNPE_ADDR_W-1:0] addr;
		logic [7:0]               wr_data;
	} nnpe_mem_req_s;

endpackage : nnpe_pkg

// *** hw/nnpe_negate_alu.sv ***
`timescale 1ns/1ps

module nnpe_negate_alu (
	input  wire logic [7:0]           operand,
	output logic [7:0]                result,
	output nnpe_pkg::nnpe_flags_s     flags
);
	import nnpe_pkg::*;

	logic [8:0] sum;
	logic [4:0] low_sum;

	// ==========================================
	// two's complement as inverted value plus one
	always_comb begin
		sum                    = {1'b0, ~operand} + 9'h001;
		low_sum                = {1'b0, ~operand[3:0]} + 5'h01;
		result                 = sum[7:0];
		flags.n                = sum[7];
		flags.overflow_flag    = (operand == 8'h80);
		flags.z                = (sum[7:0] == 8'h00);
		flags.digit_carry_flag = low_sum[4];
		flags.c                = sum[8];
	end

endmodule : nnpe_negate_alu

// *** hw/nnpe_exec.sv ***
`timescale 1ns/1ps
`include "nnpe_params.svh"

// Summary of operation
// - negate decodes replace the addressed byte with inverted value plus one.
// - negate updates N, overflow, carry, digit carry, zero; others keep flags.
// - bank bit 0 addresses the fixed access bank, ignoring the bank register.
// - bank bit 1 forms the address with the bank register's bank.
// - stack discard removes the top entry without loading it anywhere.
// - after discard, the previously pushed entry becomes the new top.
module nnpe_exec (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic [15:0]                     instr_word,
	input  wire logic                            instr_valid,
	input  wire logic [`NNPE_BANK_W-1:0]         bank_select_register,
	input  wire logic [7:0]                      mem_rd_data,
	output nnpe_pkg::nnpe_mem_req_s              mem_req,
	input  wire logic                            flags_load,
	input  nnpe_pkg::nnpe_flags_s                flags_load_data,
	output nnpe_pkg::nnpe_flags_s                status_flags,
	output logic                                 flag_wr_en,
	input  wire logic                            stack_push,
	input  wire logic [`NNPE_PC_W-1:0]           stack_push_data,
	output logic [`NNPE_PC_W-1:0]                return_stack_top,
	output logic [`NNPE_STACK_PTR_W-1:0]         stack_depth,
	output logic                                 stack_underflow,
	input  wire logic                            underflow_clear,
	output nnpe_pkg::nnpe_phase_e                q_phase,
	output nnpe_pkg::nnpe_op_e                   current_op,
	output logic                                 instr_done
);
	import nnpe_pkg::*;

	// ==========================================
	// decode helpers
	function automatic nnpe_op_e decode_op(input logic [15:0] word);
		if (word[`NNPE_NEG_OPC_MSB:`NNPE_NEG_OPC_LSB] == `NNPE_NEG_OPC) begin
			decode_op = NNPE_OP_NEG;
		end else if (word == `NNPE_POP_WORD) begin
			decode_op = NNPE_OP_POP;
		end else if (word == `NNPE_NOP_WORD || word[15:12] == `NNPE_NOP_ALT_HI) begin
			decode_op = NNPE_OP_NOP;
		end else begin
			decode_op = NNPE_OP_NONE;
		end
	endfunction : decode_op

	function automatic logic [`NNPE_ADDR_W-1:0] data_addr(
		input logic                      bank_bit,
		input logic [7:0]                offset,
		input logic [`NNPE_BANK_W-1:0]  bank
	);
		if (!bank_bit) begin
			// low half of the access bank maps to bank 0, high half to the top bank
			if (offset < `NNPE_ACCESS_SPLIT) begin
				data_addr = {`NNPE_ACCESS_LO_BANK, offset};
			end else begin
				data_addr = {`NNPE_ACCESS_HI_BANK, offset};
			end
		end else begin
			data_addr = {bank, offset};
		end
	endfunction : data_addr

	// ==========================================
	// signals
	nnpe_op_e                   op;
	logic [7:0]                 operand;
	logic [7:0]                 neg_result;
	nnpe_flags_s                neg_flags;
	logic [`NNPE_PC_W-1:0]      entries [0:`NNPE_STACK_DEPTH-1];
	logic                       do_pop;
	logic                       do_push;
	logic                       pop_ok;
	logic [`NNPE_STACK_PTR_W-1:0] next_depth;
	logic [`NNPE_STACK_PTR_W-1:0] write_idx;

	nnpe_negate_alu u_alu (
		.operand (operand),
		.result  (neg_result),
		.flags   (neg_flags)
	);

	// ==========================================
	// quarter phases, one instruction per four clocks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_phase <= NNPE_Q1;
		end else begin
			case (q_phase)
				NNPE_Q1: q_phase <= NNPE_Q2;
				NNPE_Q2: q_phase <= NNPE_Q3;
				NNPE_Q3: q_phase <= NNPE_Q4;
				NNPE_Q4: q_phase <= NNPE_Q1;
				default: q_phase <= NNPE_Q1;
			endcase
		end
	end

	// ==========================================
	// decode at end of Q1, held for the rest of the cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			op <= NNPE_OP_NONE;
		end else if (q_phase == NNPE_Q1) begin
			op <= instr_valid ? decode_op(instr_word) : NNPE_OP_NONE;
		end
	end

	assign current_op = op;

	// ==========================================
	// data memory: read in Q2, write back in Q4
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_req <= '0;
		end else begin
			case (q_phase)
				NNPE_Q1: begin
					mem_req.wr_en <= 1'b0;
					if (instr_valid && decode_op(instr_word) == NNPE_OP_NEG) begin
						mem_req.rd_en <= 1'b1;
						mem_req.addr  <= data_addr(instr_word[`NNPE_BANK_SEL_BIT],
							instr_word[7:0], bank_select_register);
					end else begin
						mem_req.rd_en <= 1'b0;
					end
				end
				NNPE_Q2: begin
					mem_req.rd_en <= 1'b0;
				end
				NNPE_Q3: begin
					// same address as the read, so the result lands in place
					if (op == NNPE_OP_NEG) begin
						mem_req.wr_en   <= 1'b1;
						mem_req.wr_data <= neg_result;
					end
				end
				NNPE_Q4: begin
					mem_req.wr_en <= 1'b0;
				end
				default: begin
					mem_req.rd_en <= 1'b0;
					mem_req.wr_en <= 1'b0;
				end
			endcase
		end
	end

	// operand captured at the end of Q2, processed during Q3
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			operand <= 8'h00;
		end else if (q_phase == NNPE_Q2 && op == NNPE_OP_NEG) begin
			operand <= mem_rd_data;
		end
	end

	// ==========================================
	// status flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_flags <= `NNPE_FLAGS_RESET;
			flag_wr_en   <= 1'b0;
		end else if (q_phase == NNPE_Q3 && op == NNPE_OP_NEG) begin
			status_flags <= neg_flags;
			flag_wr_en   <= 1'b1;
		end else begin
			flag_wr_en <= 1'b0;
			// no-op and discard leave the flags alone; the core may still load them
			if (flags_load) begin
				status_flags <= flags_load_data;
			end
		end
	end

	// ==========================================
	// completion strobe during Q4
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			instr_done <= 1'b0;
		end else begin
			instr_done <= (q_phase == NNPE_Q3) && (op != NNPE_OP_NONE);
		end
	end

	// ==========================================
	// return stack
	assign do_pop  = (q_phase == NNPE_Q4) && (op == NNPE_OP_POP);
	assign pop_ok  = do_pop && (stack_depth != `NNPE_PTR_RESET);
	assign do_push = (q_phase == NNPE_Q4) && stack_push
		&& (pop_ok || stack_depth != `NNPE_STACK_PTR_W'(`NNPE_STACK_DEPTH));

	always_comb begin
		next_depth = stack_depth;
		write_idx  = stack_depth;
		if (pop_ok && do_push) begin
			next_depth = stack_depth;
			write_idx  = stack_depth - 5'h01;
		end else if (pop_ok) begin
			next_depth = stack_depth - 5'h01;
		end else if (do_push) begin
			next_depth = stack_depth + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stack_depth <= `NNPE_PTR_RESET;
		end else begin
			stack_depth <= next_depth;
		end
	end

	// popped value is simply dropped: it feeds neither the pc nor a register
	genvar gi;
	generate
		for (gi = 0; gi < `NNPE_STACK_DEPTH; gi = gi + 1) begin : g_entry
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					entries[gi] <= `NNPE_STACK_RESET;
				end else if (do_push && write_idx == `NNPE_STACK_PTR_W'(gi)) begin
					entries[gi] <= stack_push_data;
				end
			end
		end
	endgenerate

	// top follows depth, so after a discard the earlier push shows through
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			return_stack_top <= `NNPE_STACK_RESET;
		end else if (do_push) begin
			return_stack_top <= stack_push_data;
		end else if (pop_ok) begin
			if (stack_depth > 5'h01) begin
				return_stack_top <= entries[stack_depth - 5'h02];
			end else begin
				return_stack_top <= `NNPE_STACK_RESET;
			end
		end
	end

	// sticky underflow: discard on an empty stack; the set wins over a clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stack_underflow <= 1'b0;
		end else if (do_pop && !pop_ok) begin
			stack_underflow <= 1'b1;
		end else if (underflow_clear) begin
			stack_underflow <= 1'b0;
		end
	end

endmodule : nnpe_exec

// *** dv/nnpe_exec_props.sv ***
`timescale 1ns/1ps
module nnpe_exec_props (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              flags_load,
	input wire logic              stack_push,
	input nnpe_pkg::nnpe_mem_req_s mem_req,
	input nnpe_pkg::nnpe_flags_s  status_flags,
	input wire logic              flag_wr_en,
	input wire logic [20:0]       return_stack_top,
	input wire logic [4:0]        stack_depth,
	input wire logic              stack_underflow,
	input nnpe_pkg::nnpe_phase_e  q_phase,
	input nnpe_pkg::nnpe_op_e     current_op,
	input wire logic              instr_done
);
	import nnpe_pkg::*;
	// ====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_phase_a: assert property (mem_req.rd_en |-> q_phase == NNPE_Q2)
		else $error("read strobe outside second phase");
	wr_phase_a: assert property (mem_req.wr_en |-> q_phase == NNPE_Q4 && current_op == NNPE_OP_NEG)
		else $error("write strobe outside negate");
	wr_addr_a: assert property (mem_req.wr_en |-> mem_req.addr == $past(mem_req.addr, 2))
		else $error("write address differs from read address");
	flag_hold_a: assert property ($changed(status_flags) |-> flag_wr_en || $past(flags_load))
		else $error("flags changed without cause");
	flag_neg_a: assert property (flag_wr_en |-> current_op == NNPE_OP_NEG && mem_req.wr_en)
		else $error("flag write outside negate");
	phase_walk_a: assert property (q_phase == NNPE_Q1 |=> q_phase == NNPE_Q2 ##1
		q_phase == NNPE_Q3 ##1 q_phase == NNPE_Q4 ##1 q_phase == NNPE_Q1)
		else $error("phase sequence broken");
	done_phase_a: assert property (instr_done |-> q_phase == NNPE_Q4 && current_op != NNPE_OP_NONE)
		else $error("completion outside fourth phase");
	pop_depth_a: assert property (instr_done && current_op == NNPE_OP_POP &&
		stack_depth != 5'h00 && !stack_push |=> stack_depth == $past(stack_depth) - 5'h01)
		else $error("discard did not drop one entry");
	nop_stack_a: assert property (instr_done && current_op == NNPE_OP_NOP && !stack_push
		|=> $stable(stack_depth) && $stable(return_stack_top))
		else $error("no-op touched the stack");
	pop_empty_a: assert property (instr_done && current_op == NNPE_OP_POP &&
		stack_depth == 5'h00 |=> stack_underflow)
		else $error("empty discard not flagged");
	neg_c: cover property (flag_wr_en);
	nop_c: cover property (instr_done && current_op == NNPE_OP_NOP);
	pop_c: cover property (instr_done && current_op == NNPE_OP_POP && stack_depth == 5'h00);
endmodule : nnpe_exec_props

bind nnpe_exec nnpe_exec_props props_u (.clk(clk), .rst_n(rst_n), .flags_load(flags_load),
	.stack_push(stack_push), .mem_req(mem_req), .status_flags(status_flags),
	.flag_wr_en(flag_wr_en), .return_stack_top(return_stack_top), .stack_depth(stack_depth),
	.stack_underflow(stack_underflow), .q_phase(q_phase), .current_op(current_op),
	.instr_done(instr_done));

// *** dv/nnpe_mem_model.sv ***
`timescale 1ns/1ps
module nnpe_mem_model (
	input wire logic               clk,
	input nnpe_pkg::nnpe_mem_req_s mem_req,
	output logic [7:0]             mem_rd_data
);
	import nnpe_pkg::*;
	// ====
	// data memory, bench preloads it directly
	logic [7:0] mem [0:4095];
	logic [7:0] last_rd;
	// unselected reads return the inverse so stale data is never mistaken for good
	assign mem_rd_data = mem_req.rd_en ? mem[mem_req.addr] : ~last_rd;
	always @(posedge clk) begin
		if (mem_req.rd_en) last_rd <= mem[mem_req.addr];
		if (mem_req.wr_en) mem[mem_req.addr] <= mem_req.wr_data;
	end
endmodule : nnpe_mem_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import nnpe_pkg::*;
	logic          clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, flags_load = 1'b0;
	logic          stack_push = 1'b0, underflow_clear = 1'b0;
	logic [15:0]   instr_word = 16'h0000;
	logic [3:0]    bank_select_register = 4'h0;
	logic [20:0]   stack_push_data = 21'h000000, return_stack_top;
	nnpe_flags_s   flags_load_data = 5'h00, status_flags;
	logic [7:0]    mem_rd_data, wr_d;
	nnpe_mem_req_s mem_req;
	logic          flag_wr_en, stack_underflow, instr_done, wr_seen, fwr_seen;
	logic [4:0]    stack_depth;
	logic [11:0]   wr_a;
	logic [12:0]   e;
	nnpe_phase_e   q_phase;
	nnpe_op_e      current_op;
	int            fail_count = 0, check_count = 0;
	logic [15:0]   wl [4] = '{16'h6C3A, 16'h6C90, 16'h6D00, 16'h6D10};
	logic [11:0]   al [4] = '{12'h03A, 12'hF90, 12'h500, 12'h510};
	logic [7:0]    vl [4] = '{8'h3A, 8'h80, 8'h00, 8'h10};
	logic [3:0]    bl [4] = '{4'h0, 4'h7, 4'h5, 4'h5};

	always #50 clk = ~clk;

	nnpe_exec dut_u (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
		.instr_valid(instr_valid), .bank_select_register(bank_select_register),
		.mem_rd_data(mem_rd_data), .mem_req(mem_req), .flags_load(flags_load),
		.flags_load_data(flags_load_data), .status_flags(status_flags),
		.flag_wr_en(flag_wr_en), .stack_push(stack_push), .stack_push_data(stack_push_data),
		.return_stack_top(return_stack_top), .stack_depth(stack_depth),
		.stack_underflow(stack_underflow), .underflow_clear(underflow_clear),
		.q_phase(q_phase), .current_op(current_op), .instr_done(instr_done));
	nnpe_mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_rd_data(mem_rd_data));

	// ====
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [12:0] neg_exp(input logic [7:0] v);
		logic [7:0] r;
		r = ~v + 8'h01;
		return {r, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
	endfunction : neg_exp

	// word lands in the cycle after fourth phase, results looked at in the next fourth phase
	task automatic exec(input logic [15:0] w, input logic [3:0] b, input logic dn);
		@(negedge clk);
		while (q_phase !== NNPE_Q4) @(negedge clk);
		@(posedge clk);
		instr_word <= w;
		instr_valid <= 1'b1;
		bank_select_register <= b;
		@(posedge clk);
		instr_valid <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(instr_done, dn);
		wr_seen = mem_req.wr_en;
		fwr_seen = flag_wr_en;
		wr_d = mem_req.wr_data;
		wr_a = mem_req.addr;
		@(negedge clk);
	endtask : exec

	task automatic push(input logic [20:0] d);
		@(negedge clk);
		while (q_phase !== NNPE_Q3) @(negedge clk);
		@(posedge clk);
		stack_push <= 1'b1;
		stack_push_data <= d;
		@(posedge clk);
		stack_push <= 1'b0;
		@(negedge clk);
	endtask : push

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// ====
	// sequence
	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({stack_depth, status_flags}, 10'h000);
		push(21'h014332);
		push(21'h0031A2);
		chk(return_stack_top, 21'h0031A2);
		for (int i = 0; i < 4; i++) begin
			mem_u.mem[al[i]] = vl[i];
			e = neg_exp(vl[i]);
			exec(wl[i], bl[i], 1'b1);
			chk({wr_seen, fwr_seen, wr_a}, {2'h3, al[i]});
			chk(wr_d, e[12:5]);
			chk(status_flags, e[4:0]);
			chk(mem_u.mem[al[i]], e[12:5]);
		end
		chk(stack_depth, 5'h02);
		@(posedge clk);
		flags_load <= 1'b1;
		flags_load_data <= 5'h15;
		@(posedge clk);
		flags_load <= 1'b0;
		for (int j = 0; j < 2; j++) begin
			exec(j == 0 ? 16'h0000 : 16'hF123, 4'h3, 1'b1);
			chk({wr_seen, fwr_seen, status_flags, stack_depth}, {2'h0, 5'h15, 5'h02});
		end
		exec(16'h0006, 4'h0, 1'b1);
		chk({stack_depth, return_stack_top}, {5'h01, 21'h014332});
		exec(16'h0006, 4'h0, 1'b1);
		chk({stack_depth, return_stack_top}, {5'h00, 21'h000000});
		exec(16'h0006, 4'h0, 1'b1);
		chk({stack_underflow, status_flags}, {1'h1, 5'h15});
		@(posedge clk);
		underflow_clear <= 1'b1;
		@(posedge clk);
		underflow_clear <= 1'b0;
		@(negedge clk);
		chk(stack_underflow, 1'h0);
		// unknown word: decoded as nothing, so no strobe and no state change
		exec(16'h1234, 4'h0, 1'b0);
		chk({wr_seen, fwr_seen, stack_depth, status_flags}, {2'h0, 5'h00, 5'h15});
		// fill past the top: the last push is dropped, then a discard exposes a deep entry
		for (int k = 0; k < 32; k++) push(21'(k));
		chk({stack_depth, return_stack_top}, {5'h1F, 21'h00001E});
		exec(16'h0006, 4'h0, 1'b1);
		chk({stack_depth, return_stack_top}, {5'h1E, 21'h00001D});
		test_done();
	end
endmodule : tb_top
